// ### ctt_pkg.sv
// shared constants and state types for the coincidence trigger and timing block
package ctt_pkg;
  localparam int NUM_CH   = 4;
  localparam int TB_W     = 24;
  localparam int TIME_W   = 16;
  localparam int RATE_W   = 32;
  localparam int WIN_W    = 8;
  localparam int LEVEL_W  = 3;
  // one edge-time step, and the sub-step grain the time base counts in
  localparam int STEP_PS  = 750;
  localparam int SUB_PS   = 250;
  localparam int CLK_PS   = 50000;
  localparam int SUB_PER_STEP = STEP_PS / SUB_PS;
  localparam logic [TB_W-1:0] SUB_PER_CLK = TB_W'(CLK_PS / SUB_PS);
  localparam logic [LEVEL_W-1:0] LEVEL_MIN = 3'h1;
  localparam logic [LEVEL_W-1:0] LEVEL_MAX = 3'h4;
  localparam logic [1:0] LAST_LINE = 2'h3;
  localparam logic [RATE_W-1:0] RATE_ONE = 32'h00000001;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_WINDOW  = 2'b01,
    ST_OVERLAP = 2'b10,
    ST_EMIT    = 2'b11
  } ctt_state_t;

  typedef struct packed {
    ctt_state_t                        state;
    logic [NUM_CH-1:0]                 prev;
    logic [NUM_CH-1:0]                 seen;
    logic [NUM_CH-1:0][TB_W-1:0]       lead;
    logic [NUM_CH-1:0][TB_W-1:0]       trail;
    logic [TB_W-1:0]                   trig_t;
    logic [TB_W-1:0]                   tb;
    logic [WIN_W-1:0]                  win;
    logic [1:0]                        line;
    logic                              line_valid;
    logic                              line_flag;
    logic [1:0]                        line_chan;
    logic [TIME_W-1:0]                 line_lead;
    logic [TIME_W-1:0]                 line_trail;
    logic                              line_empty;
    logic [NUM_CH-1:0][RATE_W-1:0]     single;
    logic [RATE_W-1:0]                 trig_cnt;
  } ctt_regs_t;
endpackage : ctt_pkg

// ### ctt_trigger.sv
// majority coincidence trigger, edge-time capture, event line output and rate counters
`timescale 1ns/1ns
module ctt_trigger (
  input  wire logic                                         i_clock,
  input  wire logic                                         i_rst,
  input  wire logic [ctt_pkg::NUM_CH-1:0]                   i_disc,
  input  wire logic [ctt_pkg::LEVEL_W-1:0]                  i_level,
  input  wire logic [ctt_pkg::WIN_W-1:0]                    i_window_cycles,
  input  wire logic                                         i_clear_counters,
  input  wire logic                                         i_line_ready,
  output logic                                              o_busy,
  output logic                                              o_line_valid,
  output logic                                              o_line_flag,
  output logic [1:0]                                        o_line_chan,
  output logic [ctt_pkg::TIME_W-1:0]                        o_line_lead,
  output logic [ctt_pkg::TIME_W-1:0]                        o_line_trail,
  output logic                                              o_line_empty,
  output logic [ctt_pkg::NUM_CH-1:0][ctt_pkg::RATE_W-1:0]   o_rate_single,
  output logic [ctt_pkg::RATE_W-1:0]                        o_rate_trigger
);

  ctt_pkg::ctt_regs_t r;
  ctt_pkg::ctt_regs_t next_r;

  function automatic logic [2:0] active_count(input logic [ctt_pkg::NUM_CH-1:0] v);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 0; i < ctt_pkg::NUM_CH; i++) begin
      c = c + {2'h0, v[i]};
    end
    return c;
  endfunction : active_count

  // out-of-range commands clamp rather than disable the trigger
  function automatic logic [2:0] eff_level(input logic [ctt_pkg::LEVEL_W-1:0] l);
    if (l < ctt_pkg::LEVEL_MIN) begin
      return ctt_pkg::LEVEL_MIN;
    end else if (l > ctt_pkg::LEVEL_MAX) begin
      return ctt_pkg::LEVEL_MAX;
    end
    return l;
  endfunction : eff_level

  // edge time minus trigger time, in whole 0.75 ns steps
  function automatic logic [ctt_pkg::TIME_W-1:0] rel_steps(input logic [ctt_pkg::TB_W-1:0] e,
                                                           input logic [ctt_pkg::TB_W-1:0] t);
    logic signed [ctt_pkg::TB_W-1:0] d;
    logic signed [ctt_pkg::TB_W-1:0] q;
    d = signed'(e - t);
    q = d / ctt_pkg::TB_W'(ctt_pkg::SUB_PER_STEP);
    return q[ctt_pkg::TIME_W-1:0];
  endfunction : rel_steps

  logic [2:0] cnt;
  logic [2:0] lvl;
  logic       meets;
  assign cnt   = active_count(i_disc);
  assign lvl   = eff_level(i_level);
  assign meets = cnt >= lvl;

  always_comb begin
    logic [1:0]              idx;
    logic [ctt_pkg::NUM_CH-1:0] rise;
    logic                    capture;
    logic                    load;
    idx     = 2'h0;
    rise    = i_disc & ~r.prev;
    capture = 1'b0;
    load    = 1'b0;
    next_r  = r;
    next_r.prev = i_disc;
    next_r.tb = r.tb + ctt_pkg::SUB_PER_CLK;

    for (int i = 0; i < ctt_pkg::NUM_CH; i++) begin
      // clear loses to a same-cycle count
      if (i_clear_counters) begin
        next_r.single[i] = rise[i] ? ctt_pkg::RATE_ONE : '0;
      end else if (rise[i]) begin
        next_r.single[i] = r.single[i] + ctt_pkg::RATE_ONE;
      end
    end
    if (i_clear_counters) begin
      next_r.trig_cnt = '0;
    end

    unique case (r.state)
      ctt_pkg::ST_IDLE: begin
        capture = 1'b1;
        if (cnt != 3'h0 && meets) begin
          next_r.state  = ctt_pkg::ST_OVERLAP;
          next_r.trig_t = r.tb;
          next_r.trig_cnt = (i_clear_counters ? '0 : r.trig_cnt) + ctt_pkg::RATE_ONE;
        end else if (cnt != 3'h0) begin
          next_r.state = ctt_pkg::ST_WINDOW;
          next_r.win   = i_window_cycles;
        end
      end
      ctt_pkg::ST_WINDOW: begin
        capture = 1'b1;
        if (meets) begin
          next_r.state  = ctt_pkg::ST_OVERLAP;
          next_r.trig_t = r.tb;
          next_r.trig_cnt = (i_clear_counters ? '0 : r.trig_cnt) + ctt_pkg::RATE_ONE;
        end else if (r.win == '0) begin
          // abandoned window must not re-mark channels as seen
          capture      = 1'b0;
          next_r.state = ctt_pkg::ST_IDLE;
          next_r.seen  = '0;
        end else begin
          next_r.win = r.win - 8'h01;
        end
      end
      ctt_pkg::ST_OVERLAP: begin
        capture = 1'b1;
        if (!meets) begin
          next_r.state = ctt_pkg::ST_EMIT;
          for (int i = 0; i < ctt_pkg::NUM_CH; i++) begin
            if (i_disc[i]) begin
              next_r.trail[i] = r.tb;
            end
          end
          next_r.line      = 2'h0;
          next_r.line_flag = 1'b1;
          load             = 1'b1;
        end
      end
      ctt_pkg::ST_EMIT: begin
        // edges arriving while lines drain are not recorded
        if (i_line_ready) begin
          if (r.line == ctt_pkg::LAST_LINE) begin
            next_r.state      = ctt_pkg::ST_IDLE;
            next_r.line_valid = 1'b0;
            next_r.seen       = '0;
          end else begin
            next_r.line      = r.line + 2'h1;
            next_r.line_flag = 1'b0;
            idx              = r.line + 2'h1;
            load             = 1'b1;
          end
        end
      end
    endcase

    if (capture) begin
      for (int i = 0; i < ctt_pkg::NUM_CH; i++) begin
        if (i_disc[i] && !r.seen[i]) begin
          next_r.seen[i] = 1'b1;
          next_r.lead[i] = r.tb;
        end
        if (r.prev[i] && !i_disc[i]) begin
          next_r.trail[i] = r.tb;
        end
      end
    end

    // every channel reported, one line each
    if (load) begin
      next_r.line_valid = 1'b1;
      next_r.line_chan  = idx;
      // never-active channel reads empty
      // same-cycle captures included, so line 0 agrees with later lines
      next_r.line_empty = !next_r.seen[idx];
      next_r.line_lead  = next_r.seen[idx] ? rel_steps(next_r.lead[idx], r.trig_t) : '0;
      next_r.line_trail = next_r.seen[idx] ? rel_steps(next_r.trail[idx], r.trig_t) : '0;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_busy         = r.state != ctt_pkg::ST_IDLE;
  assign o_line_valid   = r.line_valid;
  assign o_line_flag    = r.line_flag;
  assign o_line_chan    = r.line_chan;
  assign o_line_lead    = r.line_lead;
  assign o_line_trail   = r.line_trail;
  assign o_line_empty   = r.line_empty;
  assign o_rate_single  = r.single;
  assign o_rate_trigger = r.trig_cnt;

  AST_TRIG_ONCE: assert property (@(posedge i_clock) disable iff (i_rst)
    ($past(r.state) != ctt_pkg::ST_OVERLAP && r.state == ctt_pkg::ST_OVERLAP && !$past(i_clear_counters))
      |-> r.trig_cnt == $past(r.trig_cnt) + ctt_pkg::RATE_ONE)
    else $error("trigger count did not step by one");
  AST_MAJORITY: assert property (@(posedge i_clock) disable iff (i_rst)
    ((r.state == ctt_pkg::ST_IDLE || r.state == ctt_pkg::ST_WINDOW) && cnt != 3'h0 && meets)
      |=> r.state == ctt_pkg::ST_OVERLAP)
    else $error("level met but no trigger");
  AST_LEVEL_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
    (r.state != ctt_pkg::ST_OVERLAP ##1 r.state == ctt_pkg::ST_OVERLAP) |-> $past(cnt) >= $past(lvl))
    else $error("trigger below selected level");
  AST_WINDOW_OPEN: assert property (@(posedge i_clock) disable iff (i_rst)
    (r.state == ctt_pkg::ST_IDLE && cnt != 3'h0 && !meets) |=> r.state == ctt_pkg::ST_WINDOW)
    else $error("window did not open");
  AST_WINDOW_LEN: assert property (@(posedge i_clock) disable iff (i_rst)
    (r.state == ctt_pkg::ST_WINDOW && r.win == '0 && !meets) |=> r.state == ctt_pkg::ST_IDLE && r.seen == '0)
    else $error("window overran its width");
  AST_OVERLAP_END: assert property (@(posedge i_clock) disable iff (i_rst)
    (r.state == ctt_pkg::ST_OVERLAP && !meets) |=> r.state == ctt_pkg::ST_EMIT && o_line_valid && o_line_flag)
    else $error("overlap end did not start readout");
  AST_FLAG_FIRST: assert property (@(posedge i_clock) disable iff (i_rst)
    (o_line_valid && i_line_ready && r.line != ctt_pkg::LAST_LINE) |=> o_line_valid && !o_line_flag)
    else $error("continuation line carries flag");
  AST_EMPTY: assert property (@(posedge i_clock) disable iff (i_rst)
    o_line_valid |-> o_line_empty == !r.seen[o_line_chan])
    else $error("empty marker wrong");
  AST_SINGLES: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_disc[0] && !r.prev[0] && !i_clear_counters) |=> r.single[0] == $past(r.single[0]) + ctt_pkg::RATE_ONE)
    else $error("singles count missed an edge");
  AST_CLEAR: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_clear_counters && i_disc == '0) |=> r.single == '0 && r.trig_cnt == '0)
    else $error("counters not cleared");

  COV_FOURFOLD: cover property (@(posedge i_clock) disable iff (i_rst)
    r.state == ctt_pkg::ST_WINDOW && lvl == ctt_pkg::LEVEL_MAX ##1 r.state == ctt_pkg::ST_OVERLAP);
  COV_WIN_EXPIRE: cover property (@(posedge i_clock) disable iff (i_rst)
    r.state == ctt_pkg::ST_WINDOW ##1 r.state == ctt_pkg::ST_IDLE);
  COV_FULL_EVENT: cover property (@(posedge i_clock) disable iff (i_rst)
    o_line_valid && i_line_ready && r.line == ctt_pkg::LAST_LINE);

endmodule : ctt_trigger

// ### ctt_consumer_model.sv
// line consumer model standing for the readout controller
`timescale 1ns/1ns
module ctt_consumer_model (
  input  wire logic                        i_clock,
  input  wire logic                        i_rst,
  input  wire logic                        i_stall,
  input  wire logic                        i_line_valid,
  input  wire logic                        i_line_flag,
  input  wire logic [1:0]                  i_line_chan,
  input  wire logic [ctt_pkg::TIME_W-1:0]  i_line_lead,
  input  wire logic [ctt_pkg::TIME_W-1:0]  i_line_trail,
  input  wire logic                        i_line_empty,
  output logic                             o_line_ready
);
  int                                  n_lines;
  int                                  n_flags;
  int                                  bad_flag;
  logic [3:0][ctt_pkg::TIME_W-1:0]     lead;
  logic [3:0][ctt_pkg::TIME_W-1:0]     trail;
  logic [3:0]                          empty;
  // slow reader just holds ready low, never drops a line
  assign o_line_ready = !i_stall;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      n_lines  <= 0;
      n_flags  <= 0;
      bad_flag <= 0;
      lead     <= '0;
      trail    <= '0;
      empty    <= '0;
    end else if (i_line_valid && o_line_ready) begin
      n_lines <= n_lines + 1;
      n_flags <= n_flags + int'(i_line_flag);
      if (i_line_flag != (i_line_chan == 2'h0)) bad_flag <= bad_flag + 1;
      lead[i_line_chan]  <= i_line_lead;
      trail[i_line_chan] <= i_line_trail;
      empty[i_line_chan] <= i_line_empty;
    end
  end
endmodule : ctt_consumer_model

// ### ctt_trigger_tb.sv
// self-checking bench for the coincidence trigger block
`timescale 1ns/1ns
module ctt_trigger_tb;
  logic i_clock, i_rst, i_clear_counters, stall, ready, valid, flag, empty, busy;
  logic [3:0] disc;
  logic [2:0] level;
  logic [7:0] win;
  logic [1:0] chan;
  logic [15:0] lead, trail;
  logic [3:0][31:0] rs;
  logic [31:0] rt;
  int miscompares, samples_checked, base;
  ctt_trigger ctt_trigger_inst (.i_clock(i_clock), .i_rst(i_rst), .i_disc(disc), .i_level(level),
    .i_window_cycles(win), .i_clear_counters(i_clear_counters), .i_line_ready(ready), .o_busy(busy),
    .o_line_valid(valid), .o_line_flag(flag), .o_line_chan(chan), .o_line_lead(lead),
    .o_line_trail(trail), .o_line_empty(empty), .o_rate_single(rs), .o_rate_trigger(rt));
  ctt_consumer_model ctt_consumer_model_inst (.i_clock(i_clock), .i_rst(i_rst), .i_stall(stall),
    .i_line_valid(valid), .i_line_flag(flag), .i_line_chan(chan), .i_line_lead(lead),
    .i_line_trail(trail), .i_line_empty(empty), .o_line_ready(ready));
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = !i_clock;
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #2;
  endtask : step
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic wait_lines(input int n);
    int k;
    for (k = 0; k < 300 && ctt_consumer_model_inst.n_lines < n; k++) step(1);
    chk("line count", ctt_consumer_model_inst.n_lines, n);
  endtask : wait_lines
  task automatic end_of_test;
    $display("checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // two-fold walk: ch0 opens window, ch1 joins, ch1 leaves
  task automatic t_walk;
    level = 3'h2;
    win = 8'h03;
    disc = 4'h1;
    step(2);
    disc = 4'h3;
    step(3);
    disc = 4'h1;
    step(1);
    disc = 4'h0;
    wait_lines(4);
    chk("flags", ctt_consumer_model_inst.n_flags, 1);
    chk("flag order", ctt_consumer_model_inst.bad_flag, 0);
    chk("lead0", ctt_consumer_model_inst.lead[0], 32'h0000FF7B);
    chk("lead1", ctt_consumer_model_inst.lead[1], 32'h00000000);
    chk("trail0", ctt_consumer_model_inst.trail[0], 32'h000000C8);
    chk("trail1", ctt_consumer_model_inst.trail[1], 32'h000000C8);
    chk("empty", ctt_consumer_model_inst.empty, 4'hC);
    chk("lead2", ctt_consumer_model_inst.lead[2], 32'h00000000);
    chk("single0", rs[0], 32'h00000001);
    chk("single1", rs[1], 32'h00000001);
    chk("single2", rs[2], 32'h00000000);
    chk("trig", rt, 32'h00000001);
    $display("test walk done");
  endtask : t_walk
  // one channel short of the level never triggers, the full level does
  task automatic t_levels;
    int l;
    int eff;
    for (l = 0; l <= 5; l++) begin
      // 0 acts as singles, above four as four-fold
      eff = (l < 1) ? 1 : ((l > 4) ? 4 : l);
      level = 3'(l);
      base = rt;
      if (eff > 1) begin
        disc = 4'((1 << (eff - 1)) - 1);
        step(4);
        disc = 4'h0;
        step(8);
        chk("no trig", rt, base);
      end
      disc = 4'((1 << eff) - 1);
      step(2);
      disc = 4'h0;
      wait_lines(ctt_consumer_model_inst.n_lines + 4);
      chk("trig at level", rt, base + 1);
    end
    $display("test levels done");
  endtask : t_levels
  // stalled reader: no new event during readout, singles still count
  task automatic t_stall;
    level = 3'h2;
    base = ctt_consumer_model_inst.n_lines;
    stall = 1'b1;
    disc = 4'h3;
    step(2);
    disc = 4'h0;
    step(6);
    chk("busy", busy, 1'b1);
    rt_hold : begin
      int t0;
      int s3;
      t0 = rt;
      s3 = rs[3];
      disc = 4'hF;
      step(2);
      disc = 4'h0;
      step(2);
      chk("single3", rs[3], s3 + 1);
      stall = 1'b0;
      step(20);
      chk("one event", ctt_consumer_model_inst.n_lines, base + 4);
      chk("trig held", rt, t0);
    end
    chk("idle", busy, 1'b0);
    $display("test stall done");
  endtask : t_stall
  // window width sets how long an early pulse still joins the event
  task automatic t_window;
    int w;
    int late;
    level = 3'h2;
    for (w = 1; w <= 6; w += 5) begin
      for (late = 0; late <= 1; late++) begin
        win = 8'(w);
        disc = 4'h1;
        step(1);
        disc = 4'h0;
        step(w + late);
        disc = 4'h6;
        step(2);
        disc = 4'h0;
        wait_lines(ctt_consumer_model_inst.n_lines + 4);
        chk("early joins", ctt_consumer_model_inst.empty[0], 32'(late));
      end
    end
    $display("test window done");
  endtask : t_window
  // clear zeroes all counters; a rising edge in the clear cycle wins
  task automatic t_clear;
    int n;
    i_clear_counters = 1'b1;
    step(1);
    i_clear_counters = 1'b0;
    step(1);
    for (n = 0; n < 4; n++) chk("cleared single", rs[n], 32'h00000000);
    chk("cleared trig", rt, 32'h00000000);
    step(2);
    i_clear_counters = 1'b1;
    disc = 4'h1;
    step(1);
    i_clear_counters = 1'b0;
    disc = 4'h0;
    step(1);
    chk("count wins", rs[0], 32'h00000001);
    chk("other clear", rs[1], 32'h00000000);
    $display("test clear done");
  endtask : t_clear
  initial begin
    i_rst = 1'b1;
    disc = 4'h0;
    level = 3'h2;
    win = 8'h03;
    i_clear_counters = 1'b0;
    stall = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    step(12);
    i_rst = 1'b0;
    step(2);
    t_walk();
    t_levels();
    t_stall();
    step(10);
    t_window();
    t_clear();
    end_of_test();
  end
  // run needs well under a thousand cycles
  initial begin
    #(5000 * 50);
    miscompares++;
    end_of_test();
  end
endmodule : ctt_trigger_tb
